//--- design/stat_pkg.sv
// Purpose: shared constants and types for the frame statistics counter bank
// Assumes: APB with 32-bit data, one aligned word per counter
// Notes:   offsets are byte addresses of the counters
package stat_pkg;

  localparam int NUM_CNT    = 18;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int MAX_CNT_W  = 24;

  // counter indices; byte offset is index times four
  localparam int IDX_TX_GOOD      = 0;
  localparam int IDX_SINGLE_COL   = 1;
  localparam int IDX_MULTI_COL    = 2;
  localparam int IDX_RX_GOOD      = 3;
  localparam int IDX_FCS_ERR      = 4;
  localparam int IDX_ALIGN_ERR    = 5;
  localparam int IDX_DEFERRED     = 6;
  localparam int IDX_LATE_COL     = 7;
  localparam int IDX_EXCESS_COL   = 8;
  localparam int IDX_TX_UNDERRUN  = 9;
  localparam int IDX_CARRIER_LOSS = 10;
  localparam int IDX_NO_BUFFER    = 11;
  localparam int IDX_RX_OVERRUN   = 12;
  localparam int IDX_SYMBOL_ERR   = 13;
  localparam int IDX_OVERSIZE     = 14;
  localparam int IDX_JABBER       = 15;
  localparam int IDX_UNDERSIZE    = 16;
  localparam int IDX_HEARTBEAT    = 17;

  localparam logic [ADDR_W-1:0] OFS_BASE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LAST   = 8'h44;

  // width of each counter, by index
  localparam int CNT_W [NUM_CNT] = '{24, 16, 16, 24, 8, 8, 16, 8, 8,
                                     8, 8, 16, 8, 8, 8, 8, 8, 8};

  // frame length limits in bytes, then collision count limits
  localparam logic [15:0] LEN_MIN      = 16'h0040;
  localparam logic [15:0] LEN_MAX      = 16'h05EE;
  localparam logic [15:0] LEN_MIN_MCOL = 16'h003E;
  localparam logic [4:0]  COL_EXCESS   = 5'h10;
  localparam logic [4:0]  COL_MULTI_HI = 5'h0F;

  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // per-frame transmit status from the transmit engine
  typedef struct packed {
    logic        ok;
    logic [4:0]  collisions;
    logic        late_col;
    logic        deferred;
    logic        underrun;
    logic        carrier_loss;
    logic        half_duplex;
    logic        heartbeat_fail;
    logic [15:0] length;
  } tx_status_t;

  // per-frame receive status from the receive engine
  typedef struct packed {
    logic        addr_match;
    logic        fcs_bad;
    logic        odd_bits;
    logic        rx_err;
    logic        no_buffer;
    logic        overrun;
    logic [15:0] length;
  } rx_status_t;

  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } apb_req_t;

endpackage

//--- design/frame_classifier.sv
// Purpose: turns per-frame status into one increment strobe per counter
// Assumes: status valid strobes are one-cycle pulses, one frame each
// Notes:   an underrun blocks every other transmit strobe, a receive symbol error every other receive strobe
`timescale 1ns/10ps
module frame_classifier
  import stat_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               tx_valid,
  input  wire tx_status_t         tx_stat,
  input  wire logic               rx_valid,
  input  wire rx_status_t         rx_stat,
  output logic [NUM_CNT-1:0]      inc_q
);

  logic [NUM_CNT-1:0] inc_d;
  logic               tx_clean;
  logic               len_ok;
  logic               rx_len_ok;
  logic               rx_bad;

  // length range checks
  function automatic logic in_range(input logic [15:0] len, input logic [15:0] lo);
    in_range = (len >= lo) && (len <= LEN_MAX);
  endfunction

  // decode the frame status into strobes
  always_comb begin
    inc_d     = '0;
    tx_clean  = !tx_stat.underrun && !tx_stat.carrier_loss;
    len_ok    = in_range(tx_stat.length, LEN_MIN);
    rx_len_ok = in_range(rx_stat.length, LEN_MIN);
    rx_bad    = rx_stat.fcs_bad || rx_stat.rx_err;
    if (tx_valid) begin
      if (tx_stat.underrun) begin
        inc_d[IDX_TX_UNDERRUN] = 1'b1; // R13
      end else begin
        inc_d[IDX_TX_GOOD] = tx_stat.ok; // R4
        inc_d[IDX_SINGLE_COL] = tx_stat.ok && tx_clean
                                && (tx_stat.collisions == 5'h01); // R5
        inc_d[IDX_MULTI_COL] = tx_stat.ok && tx_clean && (tx_stat.collisions >= 5'h02)
                               && (tx_stat.collisions <= COL_MULTI_HI)
                               && in_range(tx_stat.length, LEN_MIN_MCOL); // R6
        inc_d[IDX_DEFERRED] = tx_stat.deferred && (tx_stat.collisions == 5'h00); // R10
        inc_d[IDX_LATE_COL] = tx_stat.late_col && tx_clean; // R11
        inc_d[IDX_EXCESS_COL] = tx_clean && (tx_stat.collisions == COL_EXCESS)
                                && len_ok; // R12
        inc_d[IDX_CARRIER_LOSS] = tx_stat.carrier_loss && tx_stat.half_duplex
                                  && (tx_stat.collisions != COL_EXCESS); // R14
        inc_d[IDX_HEARTBEAT] = tx_stat.heartbeat_fail; // R21
      end
    end
    if (rx_valid) begin
      if (rx_stat.addr_match && rx_stat.rx_err) begin
        inc_d[IDX_SYMBOL_ERR] = 1'b1; // R17
      end else begin
        inc_d[IDX_RX_GOOD] = rx_stat.addr_match && rx_len_ok && !rx_bad
                             && !rx_stat.odd_bits; // R7
        inc_d[IDX_FCS_ERR] = rx_stat.addr_match && !rx_stat.odd_bits
                             && rx_stat.fcs_bad && rx_len_ok; // R8
        inc_d[IDX_ALIGN_ERR] = rx_stat.addr_match && rx_stat.odd_bits
                               && rx_stat.fcs_bad && rx_len_ok; // R9
        inc_d[IDX_NO_BUFFER] = rx_stat.addr_match && rx_stat.no_buffer; // R15
        inc_d[IDX_RX_OVERRUN] = rx_stat.addr_match && rx_stat.overrun; // R16
        inc_d[IDX_OVERSIZE] = (rx_stat.length > LEN_MAX) && !rx_bad
                              && !rx_stat.odd_bits; // R18
        inc_d[IDX_JABBER] = (rx_stat.length > LEN_MAX)
                            && (rx_bad || rx_stat.odd_bits); // R19
        inc_d[IDX_UNDERSIZE] = (rx_stat.length < LEN_MIN) && !rx_bad
                               && !rx_stat.odd_bits; // R20
      end
    end
  end

  // register the strobes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inc_q <= '0;
    end else begin
      inc_q <= inc_d;
    end
  end

endmodule

//--- design/sat_counter.sv
// Purpose: one saturating counter that clears when read
// Assumes: clr and inc are one-cycle pulses
// Notes:   an increment in the clearing cycle restarts the count at one
`timescale 1ns/10ps
module sat_counter
  import stat_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         inc,
  input  wire logic         clr,
  output logic [W-1:0]      count_q
);

  // count, hold at all ones, clear on read without losing a coincident event
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (clr) begin
      count_q <= inc ? W'(1) : '0; // R1 R22
    end else if (inc && (count_q != {W{1'b1}})) begin
      count_q <= count_q + W'(1); // R2
    end
  end

endmodule

//--- design/mac_statistics_counters.sv
// Purpose: frame statistics counter bank of a 10/100 MAC, read over APB
// Assumes: status strobes come from the transmit and receive engines
// Notes:   every counter clears on read and saturates at all ones
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps

// Functional notes
// R1 - a software read of a counter clears it to zero
// R2 - counters stop at all ones and never wrap
// R3 - software reads often enough that no counter saturates
// R4 - 24-bit count of frames sent successfully
// R5 - 16-bit count of frames sent after exactly one collision, clean
// R6 - 16-bit count of 62-1518 byte frames sent after 2-15 collisions
// R7 - 24-bit count of good address-matched received frames, 64-1518 bytes
// R8 - 8-bit count of whole-byte matched frames with bad CRC
// R9 - 8-bit count of matched odd-length frames with bad truncated CRC
// R10 - 16-bit count of first-attempt deferrals, no underrun or collision
// R11 - 8-bit count of late collisions, also counted as collisions
// R12 - 8-bit count of 64-1518 byte frames dropped after sixteen collisions
// R13 - 8-bit count of underruns; nothing else counts that frame
// R14 - 8-bit half-duplex carrier loss count, excluding excessive collisions
// R15 - 16-bit count of matched frames dropped for lack of buffer
// R16 - 8-bit count of matched frames lost to receive overrun
// R17 - 8-bit count of matched frames with receive error; exclusive
// R18 - 8-bit count of clean received frames over 1518 bytes
// R19 - 8-bit count of errored received frames over 1518 bytes
// R20 - 8-bit count of clean received frames under 64 bytes
// R21 - 8-bit count of failed heartbeat tests after transmit
// R22 - unused upper bits read zero; a read never loses an increment
module mac_statistics_counters
  import stat_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [DATA_W-1:0]  pwdata,
  output logic [DATA_W-1:0]       prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               tx_valid,
  input  wire tx_status_t         tx_stat,
  input  wire logic               rx_valid,
  input  wire rx_status_t         rx_stat
);

  logic [NUM_CNT-1:0]   inc;
  logic [NUM_CNT-1:0]   clr;
  logic [DATA_W-1:0]    cnt_word [NUM_CNT];
  logic [DATA_W-1:0]    prdata_d;
  logic                 setup;
  logic                 hit;
  logic [4:0]           idx;
  apb_req_t             req;

  // counter words under their register names, upper bits zero
  logic [DATA_W-1:0]    tx_good_frame_count;
  logic [DATA_W-1:0]    single_collision_count;
  logic [DATA_W-1:0]    multi_collision_count;
  logic [DATA_W-1:0]    rx_good_frame_count;
  logic [DATA_W-1:0]    fcs_error_count;
  logic [DATA_W-1:0]    alignment_error_count;
  logic [DATA_W-1:0]    deferred_tx_count;
  logic [DATA_W-1:0]    late_collision_count;
  logic [DATA_W-1:0]    excess_collision_count;
  logic [DATA_W-1:0]    tx_underrun_count;
  logic [DATA_W-1:0]    carrier_loss_count;
  logic [DATA_W-1:0]    rx_no_buffer_discard_count;
  logic [DATA_W-1:0]    rx_overrun_count;
  logic [DATA_W-1:0]    symbol_error_count;
  logic [DATA_W-1:0]    oversize_frame_count;
  logic [DATA_W-1:0]    rx_jabber_count;
  logic [DATA_W-1:0]    undersize_frame_count;
  logic [DATA_W-1:0]    heartbeat_test_fail_count;

  // decode an address into a counter index, used for read and select
  function automatic logic [4:0] addr_index(input logic [ADDR_W-1:0] a);
    addr_index = a[6:2];
  endfunction

  function automatic logic addr_valid(input logic [ADDR_W-1:0] a);
    addr_valid = (a[1:0] == 2'h0) && (a <= OFS_LAST) && (a >= OFS_BASE);
  endfunction

  assign req   = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign setup = req.sel && !req.enable;
  assign idx   = addr_index(req.addr);
  assign hit   = addr_valid(req.addr);

  // per-frame status decoding
  frame_classifier u_class (
    .core_clk (core_clk),
    .rst      (rst),
    .tx_valid (tx_valid),
    .tx_stat  (tx_stat),
    .rx_valid (rx_valid),
    .rx_stat  (rx_stat),
    .inc_q    (inc)
  );

  // one counter per statistic, widths from the package table
  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : g_cnt
      logic [CNT_W[g]-1:0] count;
      sat_counter #(.W(CNT_W[g])) u_cnt (
        .core_clk (core_clk),
        .rst      (rst),
        .inc      (inc[g]),
        .clr      (clr[g]),
        .count_q  (count)
      );
      // zero-extend narrow counters
      assign cnt_word[g] = {{(DATA_W-CNT_W[g]){1'b0}}, count}; // R22
      // clear fires at the read's setup edge, in step with the data capture
      assign clr[g] = setup && !req.write && hit && (idx == 5'(g)); // R1
    end
  endgenerate

  // name each counter word so the read map stays readable
  assign tx_good_frame_count        = cnt_word[IDX_TX_GOOD];
  assign single_collision_count     = cnt_word[IDX_SINGLE_COL];
  assign multi_collision_count      = cnt_word[IDX_MULTI_COL];
  assign rx_good_frame_count        = cnt_word[IDX_RX_GOOD];
  assign fcs_error_count            = cnt_word[IDX_FCS_ERR];
  assign alignment_error_count      = cnt_word[IDX_ALIGN_ERR];
  assign deferred_tx_count          = cnt_word[IDX_DEFERRED];
  assign late_collision_count       = cnt_word[IDX_LATE_COL];
  assign excess_collision_count     = cnt_word[IDX_EXCESS_COL];
  assign tx_underrun_count          = cnt_word[IDX_TX_UNDERRUN];
  assign carrier_loss_count         = cnt_word[IDX_CARRIER_LOSS];
  assign rx_no_buffer_discard_count = cnt_word[IDX_NO_BUFFER];
  assign rx_overrun_count           = cnt_word[IDX_RX_OVERRUN];
  assign symbol_error_count         = cnt_word[IDX_SYMBOL_ERR];
  assign oversize_frame_count       = cnt_word[IDX_OVERSIZE];
  assign rx_jabber_count            = cnt_word[IDX_JABBER];
  assign undersize_frame_count      = cnt_word[IDX_UNDERSIZE];
  assign heartbeat_test_fail_count  = cnt_word[IDX_HEARTBEAT];

  // read data mux; unmapped addresses read zero
  always_comb begin
    prdata_d = RDATA_RST;
    if (hit && !req.write) begin
      case (idx)
        5'(IDX_TX_GOOD):      prdata_d = tx_good_frame_count;
        5'(IDX_SINGLE_COL):   prdata_d = single_collision_count;
        5'(IDX_MULTI_COL):    prdata_d = multi_collision_count;
        5'(IDX_RX_GOOD):      prdata_d = rx_good_frame_count;
        5'(IDX_FCS_ERR):      prdata_d = fcs_error_count;
        5'(IDX_ALIGN_ERR):    prdata_d = alignment_error_count;
        5'(IDX_DEFERRED):     prdata_d = deferred_tx_count;
        5'(IDX_LATE_COL):     prdata_d = late_collision_count;
        5'(IDX_EXCESS_COL):   prdata_d = excess_collision_count;
        5'(IDX_TX_UNDERRUN):  prdata_d = tx_underrun_count;
        5'(IDX_CARRIER_LOSS): prdata_d = carrier_loss_count;
        5'(IDX_NO_BUFFER):    prdata_d = rx_no_buffer_discard_count;
        5'(IDX_RX_OVERRUN):   prdata_d = rx_overrun_count;
        5'(IDX_SYMBOL_ERR):   prdata_d = symbol_error_count;
        5'(IDX_OVERSIZE):     prdata_d = oversize_frame_count;
        5'(IDX_JABBER):       prdata_d = rx_jabber_count;
        5'(IDX_UNDERSIZE):    prdata_d = undersize_frame_count;
        5'(IDX_HEARTBEAT):    prdata_d = heartbeat_test_fail_count;
        default:              prdata_d = RDATA_RST;
      endcase
    end
  end

  // capture read data at setup so the cleared value is never seen
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= RDATA_RST;
    end else if (setup) begin
      prdata <= prdata_d;
    end
  end

  // ready one cycle after setup: access phase always lasts one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // error on unmapped address or on any write, counters are read-only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && (!hit || req.write);
    end
  end

endmodule

//--- bench/stat_monitor.sv
// Purpose: port checker for the statistics counter bank
// Assumes: APB answer one cycle after setup
// Notes:   bound to the top module below
`timescale 1ns/10ps
module stat_monitor
  import stat_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              rx_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // setup phase, refused address, read of the undersize counter
  logic setup;
  logic bad;
  logic rd40;
  assign setup = psel && !penable;
  assign bad   = (paddr > OFS_LAST) || (paddr[1:0] != 2'h0);
  assign rd40  = setup && !pwrite && (paddr == 8'h40);
  a_setup_ready: assert property (setup |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_answer_cause: assert property (pready |-> $past(setup))
    else $error("ready without setup");
  a_write_refused: assert property (setup && pwrite |=> pslverr)
    else $error("write not refused");
  a_bad_addr: assert property (setup && !pwrite && bad |=> pslverr && prdata == RDATA_RST)
    else $error("bad address not refused");
  a_good_read: assert property (setup && !pwrite && !bad |=> !pslverr)
    else $error("mapped read refused");
  a_upper_zero: assert property (pready && !pslverr && paddr >= 8'h30 |-> !(|prdata[31:8]))
    else $error("upper bits not zero");
  a_data_holds: assert property (!setup |=> $stable(prdata))
    else $error("read data moved");
  a_read_clears: assert property (rd40 && !rx_valid && !$past(rx_valid)
    ##1 !rx_valid ##2 rd40 |=> prdata == RDATA_RST)
    else $error("counter not cleared by read");
  // main scenarios
  c_write: cover property (setup && pwrite);
  c_full: cover property (pready && prdata == 32'h0000_00FF);
  c_clear: cover property (rd40 ##3 rd40);
endmodule

bind mac_statistics_counters stat_monitor u_mon (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid));

//--- bench/stat_source.sv
// Purpose: model of the transmit and receive engines
// Assumes: one status strobe per frame
// Notes:   status fields scramble while idle
`timescale 1ns/10ps
module stat_source
  import stat_pkg::*;
(
  input  wire logic core_clk,
  output logic       tx_valid,
  output tx_status_t tx_stat,
  output logic       rx_valid,
  output rx_status_t rx_stat
);
  // idle at start
  initial begin
    tx_valid = 1'b0;
    rx_valid = 1'b0;
    tx_stat  = '0;
    rx_stat  = '0;
  end
  // one transmit frame, strobe for one cycle
  task automatic send_tx(input tx_status_t s);
    @(posedge core_clk);
    tx_valid <= 1'b1;
    tx_stat  <= s;
    @(posedge core_clk);
    tx_valid <= 1'b0;
    tx_stat  <= ~s;
  endtask
  // one receive frame, strobe for one cycle
  task automatic send_rx(input rx_status_t s);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_stat  <= s;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_stat  <= ~s;
  endtask
endmodule

//--- bench/tb_mac_statistics_counters.sv
// Purpose: self-checking bench of the statistics counter bank
// Assumes: APB master, status engines modelled
// Notes:   every frame of the transmit and receive tests is followed by a read of all counters
`timescale 1ns/10ps
module tb_mac_statistics_counters
  import stat_pkg::*;
;
  logic              core_clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic              tx_valid, rx_valid;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, d, sum;
  tx_status_t        tx_stat;
  rx_status_t        rx_stat;
  int                fail_count, checks, cyc;
  mac_statistics_counters dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid), .tx_stat(tx_stat),
    .rx_valid(rx_valid), .rx_stat(rx_stat));
  stat_source src (.core_clk(core_clk), .tx_valid(tx_valid), .tx_stat(tx_stat),
    .rx_valid(rx_valid), .rx_stat(rx_stat));
  // clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  task automatic give_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one APB transfer, result left in d and e
  task automatic apb(input logic wr, input logic [7:0] a);
    int n;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 20) fail_count++;
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // read every counter, expect one where the mask is set
  task automatic sweep(input logic [17:0] m);
    for (int i = 0; i < NUM_CNT; i++) begin
      apb(1'b0, 8'(i * 4));
      chk(d, {31'h0, m[i]});
    end
  endtask
  task automatic tf(input tx_status_t s, input logic [17:0] m);
    src.send_tx(s);
    sweep(m);
  endtask
  task automatic rf(input rx_status_t s, input logic [17:0] m);
    src.send_rx(s);
    sweep(m);
  endtask
  task automatic t_tx();
    tf({1'h1, 5'h00, 6'h00, 16'h0040}, 18'h00001);
    tf({1'h1, 5'h01, 6'h00, 16'h0040}, 18'h00003);
    tf({1'h1, 5'h03, 6'h00, 16'h003E}, 18'h00005);
    tf({1'h1, 5'h00, 6'h10, 16'h0040}, 18'h00041);
    tf({1'h0, 5'h01, 6'h20, 16'h0040}, 18'h00080);
    tf({1'h0, 5'h10, 6'h00, 16'h0040}, 18'h00100);
    tf({1'h0, 5'h10, 6'h00, 16'h003F}, 18'h00000);
    tf({1'h0, 5'h00, 6'h19, 16'h0040}, 18'h00200);
    tf({1'h0, 5'h00, 6'h06, 16'h0040}, 18'h00400);
    tf({1'h0, 5'h00, 6'h04, 16'h0040}, 18'h00000);
    tf({1'h1, 5'h00, 6'h01, 16'h0040}, 18'h20001);
  endtask
  task automatic t_rx();
    rf({6'h20, 16'h0040}, 18'h00008);
    rf({6'h30, 16'h05EE}, 18'h00010);
    rf({6'h10, 16'h0064}, 18'h00000);
    rf({6'h38, 16'h0064}, 18'h00020);
    rf({6'h22, 16'h0064}, 18'h00808);
    rf({6'h21, 16'h0040}, 18'h01008);
    rf({6'h34, 16'h07D0}, 18'h02000);
    rf({6'h00, 16'h0640}, 18'h04000);
    rf({6'h10, 16'h0640}, 18'h08000);
    rf({6'h00, 16'h003F}, 18'h10000);
  endtask
  task automatic t_sat();
    repeat (260) src.send_rx({6'h00, 16'h003F});
    apb(1'b0, 8'h40);
    chk(d, 32'h0000_00FF);
    apb(1'b0, 8'h40);
    chk(d, 32'h0000_0000);
  endtask
  // reads racing with frames lose no event
  task automatic t_race();
    sum = '0;
    fork
      repeat (20) src.send_tx({1'h1, 5'h00, 6'h00, 16'h0040});
      repeat (12) begin
        apb(1'b0, 8'h00);
        sum = sum + d;
      end
    join
    apb(1'b0, 8'h00);
    chk(sum + d, 32'h0000_0014);
  endtask
  task automatic t_bus();
    src.send_tx({1'h1, 5'h00, 6'h00, 16'h0040});
    apb(1'b1, 8'h00);
    chk({31'h0, e}, 32'h0000_0001);
    apb(1'b0, 8'h00);
    chk(d, 32'h0000_0001);
    apb(1'b0, 8'h48);
    chk({d[30:0], e}, 32'h0000_0001);
    apb(1'b0, 8'h06);
    chk({31'h0, e}, 32'h0000_0001);
  endtask
  initial begin
    rst        = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = 32'hA5A5_A5A5;
    fail_count = 0;
    checks     = 0;
    cyc        = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    sweep(18'h00000);
    t_tx();
    t_rx();
    t_sat();
    t_race();
    t_bus();
    give_verdict();
  end
endmodule
